// File: maskable_irq_mask_priority_tb.sv
// Self-checking bench for the mask and priority block.
`include "mip_defs.vh"
module maskable_irq_mask_priority_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0;
    logic        rready = 0, rfi = 0, di = 0, ei = 0, pl = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, psw_d = 0;
    logic [3:0]  ws = 0, wait_n = 0;
    logic [63:0] src = 0;
    wire         awr, wrdy, bv, arr, rv, mreq, irq, ack;
    wire [1:0]   br, rr;
    wire [31:0]  rdat, processor_status_word;
    wire [63:0]  pend;
    wire [7:0]   isp;
    wire [5:0]   asrc;
    wire [2:0]   alvl;
    int          bad_count = 0, n_checks = 0;

    mip_top u_dut (.CLOCK_I(clk), .RST_I(rst),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready), .SOURCE_REQ_I(src),
        .ACK_I(ack), .ACK_SRC_I(asrc), .ACK_LEVEL_I(alvl),
        .RETURN_FROM_INTERRUPT_I(rfi), .DISABLE_ACK_INSTRUCTION_I(di),
        .ENABLE_ACK_INSTRUCTION_I(ei), .PSW_LOAD_I(pl),
        .PSW_LOAD_DATA_I(psw_d), .PENDING_O(pend), .MASKABLE_REQ_O(mreq),
        .PROCESSOR_STATUS_WORD_O(processor_status_word), .IN_SERVICE_PRIORITY_O(isp),
        .IRQ_O(irq));
    mip_cpu_model u_cpu (.clk_i(clk), .rst_i(rst), .wait_i(wait_n),
        .req_i(mreq), .pend_i(pend), .ack_o(ack), .src_o(asrc),
        .lvl_o(alvl));

    initial
        forever #25 clk = ~clk;

    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string n, input [63:0] got, input [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask

    task axi_wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        while (!(ta && tw))
        begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
            ta = ta | awr;
            tw = tw | wrdy;
        end
        do @(posedge clk); while (bv !== 1'b1);
        bready <= 0;
        chk("bresp", br, e);
        #1;
    endtask

    task axi_rd(input [7:0] a, input [31:0] d, input [1:0] e, input string n);
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rready <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge clk); while (rv !== 1'b1);
        rready <= 0;
        chk(n, rdat, d);
        chk("rresp", rr, e);
    endtask

    // One-cycle pulse on return, disable, enable and status load strobes.
    task step(input [3:0] v);
        @(posedge clk);
        {rfi, di, ei, pl} <= v;
        @(posedge clk);
        {rfi, di, ei, pl} <= 4'h0;
        #1;
    endtask

    task req(input int k);
        @(posedge clk);
        src <= 64'h1 << k;
        @(posedge clk);
        src <= 64'h0;
        #1;
    endtask

    task wait_isp(input [7:0] e);
        for (int i = 0; i < 20 && isp !== e; i++) @(posedge clk);
        #1;
        chk("isp", isp, e);
    endtask

    task t_reset;
        chk("psw", processor_status_word, `MIP_RST_STATUS_WRD);
        chk("isp", isp, `MIP_RST_IN_SERVICE);
        axi_rd(`MIP_OFS_IN_SERVICE, 32'h0, `MIP_RESP_OKAY, "isp");
        axi_rd(`MIP_OFS_MASK1, 32'hFFFF, `MIP_RESP_OKAY, "mask1");
        axi_rd(8'h3C, 32'h0, `MIP_RESP_SLVERR, "unmapped");
        chk("mreq", mreq, 1'b0);
    endtask

    task t_alias;
        axi_wr(`MIP_OFS_MASK0, 32'hF3F6, 4'h3, `MIP_RESP_OKAY);
        axi_wr(`MIP_OFS_MASK0_HIGH, 32'hFB, 4'h1, `MIP_RESP_OKAY);
        axi_rd(`MIP_OFS_MASK0, 32'hFBF6, `MIP_RESP_OKAY, "mask0");
        axi_rd(`MIP_OFS_MASK0_HIGH, 32'hFB, `MIP_RESP_OKAY, "alias");
        axi_wr(`MIP_OFS_IN_SERVICE, 32'hFF, 4'hF, `MIP_RESP_OKAY);
        axi_rd(`MIP_OFS_IN_SERVICE, 32'h0, `MIP_RESP_OKAY, "isp_ro");
    endtask

    task t_pend;
        wait_n = 4'h5;
        req(1);
        chk("pend_masked", pend, 64'h0);
        req(0);
        chk("pend", pend, 64'h1);
        repeat (10) @(posedge clk);
        chk("isp_held", isp, 8'h00);
        step(4'h2);
        wait_isp(8'h01);
        chk("psw_dis", processor_status_word[5], 1'b1);
        axi_rd(`MIP_OFS_REQ_LOW, 32'h2, `MIP_RESP_OKAY, "flags");
        chk("irq_off", irq, 1'b0);
        axi_wr(`MIP_OFS_EVT_MASK, 32'h1, 4'h1, `MIP_RESP_OKAY);
        chk("irq_on", irq, 1'b1);
        axi_wr(`MIP_OFS_EVT_STAT, 32'h1, 4'h1, `MIP_RESP_OKAY);
        chk("irq_clr", irq, 1'b0);
    endtask

    task t_nest;
        wait_n = 4'h0;
        req(3);
        step(4'h2);
        wait_isp(8'h09);
        step(4'h8);
        chk("isp_ret", isp, 8'h08);
        for (int b = 6; b < 8; b++)
        begin
            @(posedge clk);
            psw_d <= 32'h20 | (32'h1 << b);
            step(4'h1);
            chk("psw_load", processor_status_word[7:5], psw_d[7:5]);
            step(4'h8);
            chk("isp_keep", isp, 8'h08);
        end
        @(posedge clk);
        psw_d <= 32'h20;
        step(4'h1);
        step(4'h8);
        chk("isp_last", isp, 8'h00);
        step(4'h2);
        chk("psw_en", processor_status_word[5], 1'b0);
        step(4'h4);
        chk("psw_di", processor_status_word[5], 1'b1);
        axi_rd(`MIP_OFS_EVT_STAT, 32'h3, `MIP_RESP_OKAY, "evt");
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        #1;
        t_reset;
        t_alias;
        t_pend;
        t_nest;
        stop_test;
    end

    // The whole run takes under two hundred cycles; this cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test;
    end
endmodule // maskable_irq_mask_priority_tb

// File: mip_cpu_model.sv
// Behavioural CPU core that acknowledges offered maskable requests.
module mip_cpu_model
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Cycles to wait before acknowledging.
    input  wire logic [3:0]  wait_i,
    // From the interrupt block.
    input  wire logic        req_i,
    input  wire logic [63:0] pend_i,
    // Acknowledge.
    output wire logic        ack_o,
    output wire logic [5:0]  src_o,
    output wire logic [2:0]  lvl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_ff;
    logic       ack_ff;
    logic [5:0] src_ff;
    logic [5:0] first;
    assign ack_o = ack_ff;
    assign src_o = src_ff;
    assign lvl_o = src_ff[2:0];
    // Lowest pending source index wins.
    always_comb
    begin
        first = 6'h00;
        for (int i = 63; i >= 0; i--)
            if (pend_i[i]) first = i[5:0];
    end
    // Source lines wobble while idle so a stale index is never trusted.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= 4'h0;
            ack_ff <= 1'b0;
            src_ff <= 6'h00;
        end
        else
        begin
            ack_ff <= 1'b0;
            src_ff <= ~src_ff;
            cnt_ff <= 4'h0;
            if (req_i && !ack_ff && cnt_ff == wait_i)
            begin
                ack_ff <= 1'b1;
                src_ff <= first;
            end
            else if (req_i && !ack_ff)
                cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule // mip_cpu_model

// File: mip_defs.vh
// Constants for the maskable interrupt mask and priority block.
`ifndef MIP_DEFS_VH
`define MIP_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the AXI4-Lite bus.
`define MIP_OFS_MASK0      8'h00
`define MIP_OFS_MASK1      8'h04
`define MIP_OFS_MASK2      8'h08
`define MIP_OFS_MASK3      8'h0C
`define MIP_OFS_MASK0_HIGH 8'h10
`define MIP_OFS_MASK1_HIGH 8'h14
`define MIP_OFS_MASK2_HIGH 8'h18
`define MIP_OFS_MASK3_HIGH 8'h1C
`define MIP_OFS_IN_SERVICE 8'h20
`define MIP_OFS_STATUS_WRD 8'h24
`define MIP_OFS_REQ_LOW    8'h28
`define MIP_OFS_REQ_HIGH   8'h2C
`define MIP_OFS_EVT_STAT   8'h30
`define MIP_OFS_EVT_MASK   8'h34

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define MIP_RST_MASK       16'hFFFF
`define MIP_RST_IN_SERVICE 8'h00
`define MIP_RST_STATUS_WRD 32'h00000020
`define MIP_RST_EVT        3'h0

////////////////////////////////////////////////////////////////////////////////
// Field positions in the processor status word.
`define MIP_PSW_ACK_DIS    5
`define MIP_PSW_EXC        6
`define MIP_PSW_NMI        7

////////////////////////////////////////////////////////////////////////////////
// Event bits of the interrupt status register.
`define MIP_EVT_ACK        0
`define MIP_EVT_RET        1
`define MIP_EVT_REFUSE     2
`define MIP_EVT_W          3

////////////////////////////////////////////////////////////////////////////////
// Bus responses.
`define MIP_RESP_OKAY      2'h0
`define MIP_RESP_SLVERR    2'h2

`endif

// File: mip_mask_word.v
// One 16-bit source mask word with separate low and high byte writes.
`include "mip_defs.vh"

module mip_mask_word
(
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_i,
    // Byte writes.
    input  wire        wr_lo_i,
    input  wire        wr_hi_i,
    input  wire [7:0]  lo_i,
    input  wire [7:0]  hi_i,
    // Stored mask.
    output wire [15:0] mask_o
);

reg [15:0] mask_ff;

assign mask_o = mask_ff;

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        mask_ff <= `MIP_RST_MASK;
    end
    else
    begin
        if (wr_lo_i)
        begin
            mask_ff[7:0] <= lo_i;
        end
        if (wr_hi_i)
        begin
            mask_ff[15:8] <= hi_i;
        end
    end
end

endmodule // mip_mask_word

// File: mip_monitor.sv
// Checker of the mask and priority block at its ports.
module mip_monitor
(
    input wire logic        CLOCK_I,
    input wire logic        RST_I,
    input wire logic        ACK_I,
    input wire logic [5:0]  ACK_SRC_I,
    input wire logic [2:0]  ACK_LEVEL_I,
    input wire logic        RETURN_FROM_INTERRUPT_I,
    input wire logic        DISABLE_ACK_INSTRUCTION_I,
    input wire logic        ENABLE_ACK_INSTRUCTION_I,
    input wire logic        PSW_LOAD_I,
    input wire logic [63:0] PENDING_O,
    input wire logic        MASKABLE_REQ_O,
    input wire logic [31:0] PROCESSOR_STATUS_WORD_O,
    input wire logic [7:0]  IN_SERVICE_PRIORITY_O
);
    timeunit 1ns;
    timeprecision 1ns;
    wire       dis = PROCESSOR_STATUS_WORD_O[5];
    wire       nmx = |PROCESSOR_STATUS_WORD_O[7:6];
    wire       di  = DISABLE_ACK_INSTRUCTION_I;
    wire       ei  = ENABLE_ACK_INSTRUCTION_I;
    wire       ld  = PSW_LOAD_I;
    wire [7:0] isp = IN_SERVICE_PRIORITY_O;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // An acknowledge that the block must accept.
    sequence s_ack;
        ACK_I && !dis && PENDING_O[ACK_SRC_I] && !ld;
    endsequence
    sequence s_ret;
        RETURN_FROM_INTERRUPT_I && !ACK_I && !ld;
    endsequence
    a_ack_level:
        assert property (s_ack |=> isp[$past(ACK_LEVEL_I)])
        else $error("in-service level not set on ack");
    a_ack_disable: assert property (s_ack |=> dis)
        else $error("disable flag not set on ack");
    a_ret_clear:
        assert property (s_ret ##0 !nmx |=> isp == ($past(isp) &
            ($past(isp) - 8'h01)))
        else $error("return did not clear highest level");
    a_ret_keep: assert property (s_ret ##0 nmx |=> $stable(isp))
        else $error("in-service changed on special return");
    a_dis_gate: assert property (dis |-> !MASKABLE_REQ_O)
        else $error("request offered while disabled");
    a_en_req: assert property (!dis && (|PENDING_O) |-> MASKABLE_REQ_O)
        else $error("pending request not offered");
    a_di_set: assert property (di && !ld |=> dis)
        else $error("disable did not set flag");
    a_ei_clear: assert property (ei && !di && !ld && !ACK_I |=> !dis)
        else $error("enable did not clear flag");
endmodule // mip_monitor

bind mip_top mip_monitor u_mon (.CLOCK_I, .RST_I, .ACK_I, .ACK_SRC_I,
    .ACK_LEVEL_I, .RETURN_FROM_INTERRUPT_I, .DISABLE_ACK_INSTRUCTION_I,
    .ENABLE_ACK_INSTRUCTION_I, .PSW_LOAD_I, .PENDING_O, .MASKABLE_REQ_O,
    .PROCESSOR_STATUS_WORD_O, .IN_SERVICE_PRIORITY_O);

// File: mip_top.v
// Maskable interrupt masks, in-service priority and acknowledge-disable flag.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "mip_defs.vh"

module mip_top
(
    // Clock and reset.
    input  wire        CLOCK_I,
    input  wire        RST_I,
    // AXI4-Lite write address channel.
    input  wire [7:0]  S_AXI_AWADDR_I,
    input  wire        S_AXI_AWVALID_I,
    output wire        S_AXI_AWREADY_O,
    // AXI4-Lite write data channel.
    input  wire [31:0] S_AXI_WDATA_I,
    input  wire [3:0]  S_AXI_WSTRB_I,
    input  wire        S_AXI_WVALID_I,
    output wire        S_AXI_WREADY_O,
    // AXI4-Lite write response channel.
    output wire [1:0]  S_AXI_BRESP_O,
    output wire        S_AXI_BVALID_O,
    input  wire        S_AXI_BREADY_I,
    // AXI4-Lite read address channel.
    input  wire [7:0]  S_AXI_ARADDR_I,
    input  wire        S_AXI_ARVALID_I,
    output wire        S_AXI_ARREADY_O,
    // AXI4-Lite read data channel.
    output wire [31:0] S_AXI_RDATA_O,
    output wire [1:0]  S_AXI_RRESP_O,
    output wire        S_AXI_RVALID_O,
    input  wire        S_AXI_RREADY_I,
    // Peripheral request pulses, one per source.
    input  wire [63:0] SOURCE_REQ_I,
    // CPU acknowledge of a maskable request.
    input  wire        ACK_I,
    input  wire [5:0]  ACK_SRC_I,
    input  wire [2:0]  ACK_LEVEL_I,
    // CPU instruction strobes and status word restore.
    input  wire        RETURN_FROM_INTERRUPT_I,
    input  wire        DISABLE_ACK_INSTRUCTION_I,
    input  wire        ENABLE_ACK_INSTRUCTION_I,
    input  wire        PSW_LOAD_I,
    input  wire [31:0] PSW_LOAD_DATA_I,
    // Towards the CPU core.
    output wire [63:0] PENDING_O,
    output wire        MASKABLE_REQ_O,
    output wire [31:0] PROCESSOR_STATUS_WORD_O,
    output wire [7:0]  IN_SERVICE_PRIORITY_O,
    // Interrupt line to the system.
    output wire        IRQ_O
);

////////////////////////////////////////////////////////////////////////////////
// State.
reg [7:0]              in_service_priority_ff;
reg [7:0]              nxt_in_service;
reg [31:0]             processor_status_word_ff;
reg [31:0]             nxt_psw;
reg [63:0]             source_request_flag_ff;
reg [63:0]             nxt_req;
reg [`MIP_EVT_W-1:0]   evt_stat_ff;
reg [`MIP_EVT_W-1:0]   nxt_evt_stat;
reg [`MIP_EVT_W-1:0]   evt_mask_ff;
reg [7:0]              clr_bit;
reg [63:0]             req_clr;
integer                i;

wire [63:0]            mask_all;
wire [63:0]            pending;
wire                   ack_dis;
wire                   ack_ok;
wire                   ret_clear;
wire [`MIP_EVT_W-1:0]  evt;
wire                   clr_lo_hit;
wire                   clr_hi_hit;

////////////////////////////////////////////////////////////////////////////////
// Write side of the bus slave.
reg        aw_got_ff;
reg        w_got_ff;
reg [7:0]  aw_addr_ff;
reg [31:0] w_data_ff;
reg [3:0]  w_strb_ff;
reg        bvalid_ff;
reg [1:0]  bresp_ff;
wire       do_wr;
reg        wr_hit;

assign S_AXI_AWREADY_O = ~aw_got_ff;
assign S_AXI_WREADY_O  = ~w_got_ff;
assign S_AXI_BVALID_O  = bvalid_ff;
assign S_AXI_BRESP_O   = bresp_ff;
assign do_wr           = aw_got_ff & w_got_ff & ~bvalid_ff;

always @(posedge CLOCK_I or posedge RST_I)
begin
    if (RST_I)
    begin
        aw_got_ff  <= 1'b0;
        w_got_ff   <= 1'b0;
        aw_addr_ff <= 8'h00;
        w_data_ff  <= 32'h00000000;
        w_strb_ff  <= 4'h0;
        bvalid_ff  <= 1'b0;
        bresp_ff   <= `MIP_RESP_OKAY;
    end
    else
    begin
        if (S_AXI_AWVALID_I && !aw_got_ff)
        begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !w_got_ff)
        begin
            w_got_ff  <= 1'b1;
            w_data_ff <= S_AXI_WDATA_I;
            w_strb_ff <= S_AXI_WSTRB_I;
        end
        if (do_wr)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `MIP_RESP_OKAY : `MIP_RESP_SLVERR;
        end
        else if (bvalid_ff && S_AXI_BREADY_I)
        begin
            bvalid_ff <= 1'b0;
        end
    end
end

// Address decode of a write; the in-service and status words take no data.
always @*
begin
    case (aw_addr_ff)
        `MIP_OFS_MASK0, `MIP_OFS_MASK1, `MIP_OFS_MASK2, `MIP_OFS_MASK3,
        `MIP_OFS_MASK0_HIGH, `MIP_OFS_MASK1_HIGH, `MIP_OFS_MASK2_HIGH,
        `MIP_OFS_MASK3_HIGH, `MIP_OFS_IN_SERVICE, `MIP_OFS_STATUS_WRD,
        `MIP_OFS_REQ_LOW, `MIP_OFS_REQ_HIGH, `MIP_OFS_EVT_STAT,
        `MIP_OFS_EVT_MASK:
            wr_hit = 1'b1;
        default:
            wr_hit = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Source mask words, each with a full-word view and a high-byte alias.
genvar g;
generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_mask
        wire sel_word = do_wr && (aw_addr_ff == 8'h00 + 8'h04 * g);
        wire sel_high = do_wr && (aw_addr_ff == `MIP_OFS_MASK0_HIGH
                                               + 8'h04 * g);
        wire [7:0] high_data = sel_high ? w_data_ff[7:0]
                                        : w_data_ff[15:8];

        mip_mask_word u_mask
        (
            .clk_i   (CLOCK_I),
            .rst_i   (RST_I),
            .wr_lo_i (sel_word & w_strb_ff[0]),
            .wr_hi_i ((sel_word & w_strb_ff[1])
                      | (sel_high & w_strb_ff[0])),
            .lo_i    (w_data_ff[7:0]),
            .hi_i    (high_data),
            .mask_o  (mask_all[16*g+15:16*g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Request recording, pending view and acknowledge gating.
assign ack_dis   = processor_status_word_ff[`MIP_PSW_ACK_DIS];
assign pending   = source_request_flag_ff & ~mask_all;
assign ack_ok    = ACK_I & ~ack_dis & pending[ACK_SRC_I];
assign ret_clear = RETURN_FROM_INTERRUPT_I
                   & ~processor_status_word_ff[`MIP_PSW_NMI]
                   & ~processor_status_word_ff[`MIP_PSW_EXC];
assign clr_lo_hit = do_wr & (aw_addr_ff == `MIP_OFS_REQ_LOW);
assign clr_hi_hit = do_wr & (aw_addr_ff == `MIP_OFS_REQ_HIGH);

assign PENDING_O      = pending;
assign MASKABLE_REQ_O = (|pending) & ~ack_dis;

always @*
begin
    req_clr = 64'h0;
    for (i = 0; i < 32; i = i + 1)
    begin
        req_clr[i]    = clr_lo_hit & w_data_ff[i] & w_strb_ff[i/8];
        req_clr[32+i] = clr_hi_hit & w_data_ff[i] & w_strb_ff[i/8];
    end
    if (ack_ok)
    begin
        req_clr[ACK_SRC_I] = 1'b1;
    end
    // A masked or held request keeps its flag until taken or cleared.
    nxt_req = (source_request_flag_ff & ~req_clr) | SOURCE_REQ_I;
end

////////////////////////////////////////////////////////////////////////////////
// In-service priority: lowest set level is the highest priority.
always @*
begin
    // Isolates the lowest set bit, the highest-priority level in service.
    clr_bit = in_service_priority_ff & (~in_service_priority_ff + 8'h01);
    nxt_in_service = in_service_priority_ff;
    if (ret_clear)
    begin
        nxt_in_service = nxt_in_service & ~clr_bit;
    end
    if (ack_ok)
    begin
        nxt_in_service[ACK_LEVEL_I] = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Processor status word and its acknowledge-disable flag.
always @*
begin
    nxt_psw = processor_status_word_ff;
    if (PSW_LOAD_I)
    begin
        nxt_psw = PSW_LOAD_DATA_I;
    end
    if (DISABLE_ACK_INSTRUCTION_I)
    begin
        nxt_psw[`MIP_PSW_ACK_DIS] = 1'b1;
    end
    else if (ENABLE_ACK_INSTRUCTION_I)
    begin
        nxt_psw[`MIP_PSW_ACK_DIS] = 1'b0;
    end
    if (ack_ok)
    begin
        nxt_psw[`MIP_PSW_ACK_DIS] = 1'b1;
    end
end

always @(posedge CLOCK_I or posedge RST_I)
begin
    if (RST_I)
    begin
        in_service_priority_ff   <= `MIP_RST_IN_SERVICE;
        processor_status_word_ff <= `MIP_RST_STATUS_WRD;
        source_request_flag_ff   <= 64'h0;
    end
    else
    begin
        in_service_priority_ff   <= nxt_in_service;
        processor_status_word_ff <= nxt_psw;
        source_request_flag_ff   <= nxt_req;
    end
end

assign PROCESSOR_STATUS_WORD_O = processor_status_word_ff;
assign IN_SERVICE_PRIORITY_O   = in_service_priority_ff;

////////////////////////////////////////////////////////////////////////////////
// Event status, write one to clear, with a new event winning the clear.
assign evt[`MIP_EVT_ACK]    = ack_ok;
assign evt[`MIP_EVT_RET]    = ret_clear & (|in_service_priority_ff);
assign evt[`MIP_EVT_REFUSE] = ACK_I & ~ack_ok;

always @*
begin
    nxt_evt_stat = evt_stat_ff;
    if (do_wr && aw_addr_ff == `MIP_OFS_EVT_STAT && w_strb_ff[0])
    begin
        nxt_evt_stat = evt_stat_ff & ~w_data_ff[`MIP_EVT_W-1:0];
    end
    nxt_evt_stat = nxt_evt_stat | evt;
end

always @(posedge CLOCK_I or posedge RST_I)
begin
    if (RST_I)
    begin
        evt_stat_ff <= `MIP_RST_EVT;
        evt_mask_ff <= `MIP_RST_EVT;
    end
    else
    begin
        evt_stat_ff <= nxt_evt_stat;
        if (do_wr && aw_addr_ff == `MIP_OFS_EVT_MASK && w_strb_ff[0])
        begin
            evt_mask_ff <= w_data_ff[`MIP_EVT_W-1:0];
        end
    end
end

assign IRQ_O = |(evt_stat_ff & evt_mask_ff);

////////////////////////////////////////////////////////////////////////////////
// Read side of the bus slave.
reg        rvalid_ff;
reg [31:0] rdata_ff;
reg [1:0]  rresp_ff;
reg [31:0] rd_mux;
reg        rd_hit;

assign S_AXI_ARREADY_O = ~rvalid_ff;
assign S_AXI_RVALID_O  = rvalid_ff;
assign S_AXI_RDATA_O   = rdata_ff;
assign S_AXI_RRESP_O   = rresp_ff;

always @*
begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (S_AXI_ARADDR_I)
        `MIP_OFS_MASK0:      rd_mux[15:0] = mask_all[15:0];
        `MIP_OFS_MASK1:      rd_mux[15:0] = mask_all[31:16];
        `MIP_OFS_MASK2:      rd_mux[15:0] = mask_all[47:32];
        `MIP_OFS_MASK3:      rd_mux[15:0] = mask_all[63:48];
        `MIP_OFS_MASK0_HIGH: rd_mux[7:0]  = mask_all[15:8];
        `MIP_OFS_MASK1_HIGH: rd_mux[7:0]  = mask_all[31:24];
        `MIP_OFS_MASK2_HIGH: rd_mux[7:0]  = mask_all[47:40];
        `MIP_OFS_MASK3_HIGH: rd_mux[7:0]  = mask_all[63:56];
        `MIP_OFS_IN_SERVICE: rd_mux[7:0]  = in_service_priority_ff;
        `MIP_OFS_STATUS_WRD: rd_mux       = processor_status_word_ff;
        `MIP_OFS_REQ_LOW:    rd_mux       = source_request_flag_ff[31:0];
        `MIP_OFS_REQ_HIGH:   rd_mux       = source_request_flag_ff[63:32];
        `MIP_OFS_EVT_STAT:   rd_mux[`MIP_EVT_W-1:0] = evt_stat_ff;
        `MIP_OFS_EVT_MASK:   rd_mux[`MIP_EVT_W-1:0] = evt_mask_ff;
        default:             rd_hit = 1'b0;
    endcase
end

always @(posedge CLOCK_I or posedge RST_I)
begin
    if (RST_I)
    begin
        rvalid_ff <= 1'b0;
        rdata_ff  <= 32'h00000000;
        rresp_ff  <= `MIP_RESP_OKAY;
    end
    else if (S_AXI_ARVALID_I && !rvalid_ff)
    begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= rd_hit ? `MIP_RESP_OKAY : `MIP_RESP_SLVERR;
    end
    else if (rvalid_ff && S_AXI_RREADY_I)
    begin
        rvalid_ff <= 1'b0;
    end
end

endmodule // mip_top
